// ---- src/pspp_pkg.sv ----
package pspp_pkg;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int unsigned MAIN_WIDTH = 20;
    localparam int unsigned ENH_WIDTH  = 8;
    localparam logic [19:0] MAIN_RESET = 20'h00000;
    localparam logic [7:0]  ENH_RESET  = 8'h00;

    // Synchroniser depth for pin inputs
    localparam int unsigned SYNC_STAGES = 2;

    // Synchroniser start value at pin idle levels: strobe high, mode pin high
    // Starting at zero would fake a strobe edge and a data-out enable at release
    localparam logic [5:0]  SYNC_RESET  = 6'h09;

    // Serial pin group as sampled from outside
    typedef struct packed {
        logic serial_clock;
        logic serial_data;
        logic load_strobe;
        logic enh_select;
    } pspp_serial_type;

    // Phase detector up and down pulses
    typedef struct packed {
        logic phase_up_pulse;
        logic phase_down_pulse;
    } pspp_phase_type;

    // Charge pump drive: source and sink enables
    typedef struct packed {
        logic source;
        logic sink;
    } pspp_pump_type;

endpackage : pspp_pkg

// ---- src/pspp_serial_port.sv ----
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Enhancement select low: each serial clock rise shifts data into 20-bit main register.
// - Enhancement select high: shift into 8-bit enhancement register, main register untouched.
// - Words arrive MSB first; first shifted bit ends as the top bit.
// - Main register shifts only while the load strobe is low.
// - Load strobe rising edge copies whole main register into holding register.
// - Counter source select 1 uses main register, 0 uses holding register.
// - Enhancement bits take effect only while enhancement mode input is low.
// - Filter capacitor output is NAND of up and down phase pulses.
// - Lock indicator is open drain: drives low only while both phase pulses are high, floats otherwise.
// - Charge pump sources when reference leads, sinks when reference lags.
// - Data out pin is enabled only while enhancement mode is active.
module pspp_serial_port (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     reset,
    // Serial pins, asynchronous
    input  wire pspp_pkg::pspp_serial_type serial_pins,
    input  wire logic                     counter_source_select,
    input  wire logic                     enh_mode_n,
    // Phase detector, same clock
    input  wire pspp_pkg::pspp_phase_type phase_in,
    input  wire logic                     data_out_src,
    // Counter program word and enhancement bits
    output logic [19:0]                   counter_word,
    output logic [7:0]                    enh_bits,
    // Loop outputs
    output logic                          filter_cap_out,
    output logic                          lock_indicator_out,
    output logic                          lock_indicator_oe,
    output pspp_pkg::pspp_pump_type       charge_pump_out,
    // Data out pin
    output logic                          data_out,
    output logic                          data_out_oe
);
    import pspp_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic       sclk_prev_r;
    logic       load_prev_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1_r <= SYNC_RESET;
            sync2_r <= SYNC_RESET;
        end else begin
            sync1_r <= {serial_pins, counter_source_select, enh_mode_n};
            sync2_r <= sync1_r;
        end
    end

    logic sclk_s;
    logic sdata_s;
    logic load_s;
    logic esel_s;
    logic fsel_s;
    logic enh_n_s;
    assign {sclk_s, sdata_s, load_s, esel_s, fsel_s, enh_n_s} = sync2_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sclk_prev_r <= 1'b0;
            load_prev_r <= 1'b1;
        end else begin
            sclk_prev_r <= sclk_s;
            load_prev_r <= load_s;
        end
    end

    logic sclk_rise;
    logic load_rise;
    assign sclk_rise = sclk_s & ~sclk_prev_r;
    assign load_rise = load_s & ~load_prev_r;

    // ****************************************
    // Shift registers
    // ****************************************
    logic [19:0] main_r;
    logic [19:0] main_nxt;
    logic [7:0]  enh_r;
    logic [7:0]  enh_nxt;
    logic [19:0] hold_r;

    assign main_nxt = {main_r[18:0], sdata_s};
    assign enh_nxt  = {enh_r[6:0], sdata_s};

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            main_r <= MAIN_RESET;
        end else if (sclk_rise && !esel_s && !load_s) begin
            main_r <= main_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            enh_r <= ENH_RESET;
        end else if (sclk_rise && esel_s) begin
            enh_r <= enh_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hold_r <= MAIN_RESET;
        end else if (load_rise) begin
            hold_r <= main_r;
        end
    end

    // ****************************************
    // Counter programming
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            counter_word <= MAIN_RESET;
            enh_bits     <= ENH_RESET;
        end else begin
            counter_word <= fsel_s ? main_r : hold_r;
            enh_bits     <= enh_n_s ? ENH_RESET : enh_r;
        end
    end

    // ****************************************
    // Lock detect, pump, data out
    // ****************************************
    logic nand_v;
    assign nand_v = ~(phase_in.phase_up_pulse & phase_in.phase_down_pulse);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            filter_cap_out     <= 1'b1;
            lock_indicator_out <= 1'b0;
            lock_indicator_oe  <= 1'b0;
        end else begin
            filter_cap_out     <= nand_v;
            lock_indicator_out <= 1'b0;
            lock_indicator_oe  <= ~nand_v;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            charge_pump_out <= '0;
        end else begin
            charge_pump_out.source <= phase_in.phase_up_pulse & ~phase_in.phase_down_pulse;
            charge_pump_out.sink   <= phase_in.phase_down_pulse & ~phase_in.phase_up_pulse;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            data_out    <= 1'b0;
            data_out_oe <= 1'b0;
        end else begin
            data_out    <= data_out_src & ~enh_n_s;
            data_out_oe <= ~enh_n_s;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    // main shift
    main_shift_a : assert property (@(posedge clk_sys) disable iff (reset)
        sclk_rise && !esel_s && !load_s |=> main_r == $past(main_nxt))
        else $error("main register did not shift");
    enh_keep_main_a : assert property (@(posedge clk_sys) disable iff (reset)
        esel_s |=> $stable(main_r))
        else $error("main register changed in enhancement select");
    enh_shift_a : assert property (@(posedge clk_sys) disable iff (reset)
        sclk_rise && esel_s |=> enh_r[0] == $past(sdata_s) && enh_r[7:1] == $past(enh_r[6:0]))
        else $error("enhancement shift order wrong");
    strobe_block_a : assert property (@(posedge clk_sys) disable iff (reset)
        load_s |=> $stable(main_r))
        else $error("main register shifted with strobe high");
    hold_load_a : assert property (@(posedge clk_sys) disable iff (reset)
        load_rise |=> hold_r == $past(main_r))
        else $error("holding register not loaded");
    hold_keep_a : assert property (@(posedge clk_sys) disable iff (reset)
        !load_rise |=> $stable(hold_r))
        else $error("holding register changed without strobe edge");
    source_sel_a : assert property (@(posedge clk_sys) disable iff (reset)
        ##1 counter_word == ($past(fsel_s) ? $past(main_r) : $past(hold_r)))
        else $error("counter word from wrong source");
    enh_gate_a : assert property (@(posedge clk_sys) disable iff (reset)
        enh_n_s |=> enh_bits == ENH_RESET)
        else $error("enhancement bits active outside mode");
    nand_out_a : assert property (@(posedge clk_sys) disable iff (reset)
        ##1 filter_cap_out == !($past(phase_in.phase_up_pulse) && $past(phase_in.phase_down_pulse)))
        else $error("filter output is not nand of pulses");
    lock_drive_a : assert property (@(posedge clk_sys) disable iff (reset)
        ##1 lock_indicator_oe == ($past(phase_in.phase_up_pulse) && $past(phase_in.phase_down_pulse))
            && !lock_indicator_out)
        else $error("lock indicator drive wrong");
    pump_excl_a : assert property (@(posedge clk_sys) disable iff (reset)
        !(charge_pump_out.source && charge_pump_out.sink))
        else $error("pump sources and sinks together");
    pump_dir_a : assert property (@(posedge clk_sys) disable iff (reset)
        ##1 charge_pump_out.source == ($past(phase_in.phase_up_pulse) && !$past(phase_in.phase_down_pulse))
            && charge_pump_out.sink == ($past(phase_in.phase_down_pulse) && !$past(phase_in.phase_up_pulse)))
        else $error("pump direction wrong");
    dout_gate_a : assert property (@(posedge clk_sys) disable iff (reset)
        enh_n_s |=> !data_out_oe && !data_out)
        else $error("data out active outside enhancement mode");

endmodule : pspp_serial_port

`default_nettype wire

// ---- sim/pspp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pspp_host_model
    import pspp_pkg::*;
(
    // Clock reference
    input  wire logic                 clk_sys,
    // Pins toward the device
    output pspp_pkg::pspp_serial_type serial_pins
);
    initial begin
        serial_pins = 4'b0010;
    end
    task automatic wait_neg(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_neg
    task automatic send_bits(input logic [19:0] word, input int n, input logic to_enh);
        serial_pins.enh_select = to_enh;
        for (int i = n - 1; i >= 0; i--) begin
            serial_pins.serial_data = word[i];
            wait_neg(12);
            serial_pins.serial_clock = 1'b1;
            wait_neg(13);
            serial_pins.serial_clock = 1'b0;
        end
        // Released data toggles, so a stale bit never looks valid
        serial_pins.serial_data = ~serial_pins.serial_data;
        serial_pins.enh_select  = 1'b0;
        wait_neg(8);
    endtask : send_bits
    task automatic set_strobe(input logic level);
        serial_pins.load_strobe = level;
        wait_neg(8);
    endtask : set_strobe
endmodule : pspp_host_model
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pspp_pkg::*;
    logic            clk_sys = 1'b0;
    logic            reset   = 1'b1;
    pspp_serial_type pins;
    logic            sel     = 1'b0;
    logic            enh_n   = 1'b1;
    pspp_phase_type  phase   = 2'b00;
    logic            dsrc    = 1'b0;
    logic [19:0]     word;
    logic [7:0]      enh;
    logic            fcap, lock_out, lock_oe, dout, dout_oe;
    pspp_pump_type   pump;
    int              mismatches = 0;
    int              num_checks = 0;

    always #2.5 clk_sys = ~clk_sys;

    pspp_host_model host_u (.clk_sys(clk_sys), .serial_pins(pins));
    pspp_serial_port dut_u (.clk_sys(clk_sys), .reset(reset), .serial_pins(pins),
        .counter_source_select(sel), .enh_mode_n(enh_n), .phase_in(phase), .data_out_src(dsrc),
        .counter_word(word), .enh_bits(enh), .filter_cap_out(fcap), .lock_indicator_out(lock_out),
        .lock_indicator_oe(lock_oe), .charge_pump_out(pump), .data_out(dout), .data_out_oe(dout_oe));

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic test_main_load;
        host_u.set_strobe(1'b0);
        sel = 1'b1;
        host_u.send_bits(20'hA5C3E, 20, 1'b0);
        check(word, 20'hA5C3E);
        sel = 1'b0;
        tick(6);
        check(word, 20'h00000);
        host_u.set_strobe(1'b1);
        check(word, 20'hA5C3E);
        $display("Test main load done");
    endtask : test_main_load
    task automatic test_enh;
        host_u.send_bits(20'h0005A, 8, 1'b1);
        check(enh, 8'h00);
        check(dout_oe, 1'b0);
        enh_n = 1'b0;
        dsrc  = 1'b1;
        sel   = 1'b1;
        tick(6);
        check(enh, 8'h5A);
        check(word, 20'hA5C3E);
        check({dout_oe, dout}, 2'b11);
        $display("Test enhancement done");
    endtask : test_enh
    task automatic test_refuse;
        host_u.send_bits(20'h3C0F1, 20, 1'b0);
        check(word, 20'hA5C3E);
        sel = 1'b0;
        tick(6);
        check(word, 20'hA5C3E);
        $display("Test refused shift done");
    endtask : test_refuse
    task automatic test_phase;
        for (int i = 0; i < 4; i++) begin
            phase = i[1:0];
            tick(4);
            check(fcap, !(i[1] && i[0]));
            check({lock_out, lock_oe}, {1'b0, i[1] & i[0]});
            check(pump, {i[1] & ~i[0], i[0] & ~i[1]});
        end
        $display("Test phase loop done");
    endtask : test_phase

    initial begin
        tick(4);
        reset = 1'b0;
        tick(3);
        test_main_load();
        test_enh();
        test_refuse();
        test_phase();
        stop_test();
    end
    // About 1280 cycles expected; generous margin
    initial begin
        #100us;
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
